// >>> common/umr_pkg.sv
package umr_pkg;

	// Mode-register addresses.
	localparam logic [7:0] ADDR_REV_ONE   = 8'h06;
	localparam logic [7:0] ADDR_REV_TWO   = 8'h07;
	localparam logic [7:0] ADDR_GEOMETRY  = 8'h08;
	localparam logic [7:0] ADDR_VEND_TEST = 8'h09;
	localparam logic [7:0] ADDR_CAL_CMD   = 8'h0A;
	localparam logic [7:0] ADDR_RSV_LO    = 8'h0B;
	localparam logic [7:0] ADDR_RSV_HI    = 8'h0F;
	localparam logic [7:0] ADDR_BANK_MASK = 8'h10;
	localparam logic [7:0] ADDR_SEG_MASK  = 8'h11;
	localparam logic [7:0] ADDR_SOFT_RST  = 8'h3F;

	// Calibration command codes.
	localparam logic [7:0] CAL_INIT  = 8'hFF;
	localparam logic [7:0] CAL_LONG  = 8'hAB;
	localparam logic [7:0] CAL_SHORT = 8'h56;
	localparam logic [7:0] CAL_RESET = 8'hC3;

	// Geometry field layout.
	localparam int TYPE_LSB    = 0;
	localparam int DENS_LSB    = 2;
	localparam int WIDTH_LSB   = 6;
	localparam logic [1:0] WIDTH_X32 = 2'h0;
	localparam logic [1:0] WIDTH_X16 = 2'h1;
	localparam logic [1:0] WIDTH_X8  = 2'h2;
	localparam logic [3:0] DENS_1GB  = 4'h4;
	localparam logic [3:0] DENS_2GB  = 4'h5;
	localparam logic [3:0] DENS_4GB  = 4'h6;
	localparam logic [3:0] DENS_8GB  = 4'h7;
	localparam logic [3:0] DENS_MAX  = 4'h9;

	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] BANK4_KEEP = 8'h0F;
	localparam logic [7:0] DATA_ZERO  = 8'h00;

	// Row-address position of the segment select bits per density.
	localparam int SEG_LSB_1GB = 10;
	localparam int SEG_LSB_2GB = 11;
	localparam int SEG_LSB_8GB = 12;

	typedef enum logic [2:0] {
		CAL_NONE   = 3'h0,
		CAL_DO_INI = 3'h1,
		CAL_DO_LNG = 3'h2,
		CAL_DO_SHT = 3'h3,
		CAL_DO_RST = 3'h4
	} umr_cal_e;

	typedef enum logic [1:0] {
		HS_IDLE = 2'h0,
		HS_WAIT = 2'h1,
		HS_DONE = 2'h3
	} umr_hs_e;

endpackage : umr_pkg

// >>> common/umr_if.sv
interface umr_if;
	logic       req;
	logic       wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       ack;
	logic [7:0] rdata;

	modport ctrl (output req, output wr, output addr, output wdata, input ack, input rdata);
	modport dev  (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface : umr_if

// >>> rtl/umr_device.sv
// How it works
// RQ1: Address 06h reads fixed first revision.
// RQ2: Address 07h reads vendor second revision.
// RQ3: 08h: type bits 1:0, width 7:6.
// RQ4: 08h bits 5:2 report density code.
// RQ5: Calibration codes AB long, 56 short, C3.
// RQ6: Code FF starts post-initialisation calibration.
// RQ7: Controller writes only the four codes.
// RQ8: Reserved calibration codes are ignored entirely.
// RQ9: Pin at supply: ignore all calibration.
// RQ10: Resistor to ground: commands or default.
// RQ11: Bank mask at 10h, 1 blocks refresh.
// RQ12: Four-bank parts use bank bits 3:0.
// RQ13: Segment mask at 11h, 1 blocks refresh.
// RQ14: Segment mask only for 1Gb-8Gb parts.
// RQ15: Segment n covers top row bits n.
// RQ16: Addresses 0Bh-0Fh reserved, no function.
// RQ17: Controller avoids unused and vendor ranges.
// RQ18: Controller avoids 14h-1Fh nonvolatile addresses.
// RQ19: 09h is vendor test, inert normally.
// RQ20: 3Fh write-only reset, data ignored.
// RQ21: Reset write restores masks and calibration.
// RQ22: 8-bit address; reads never change state.
module umr_device #(
	parameter logic [7:0] REV_ONE    = 8'h5A, // Arbitrary value.
	parameter logic [7:0] REV_TWO    = 8'hA5, // Arbitrary value.
	parameter logic [1:0] MEM_TYPE   = 2'h0,
	parameter logic [3:0] DENSITY    = umr_pkg::DENS_2GB,
	parameter logic [1:0] IO_WIDTH   = umr_pkg::WIDTH_X16,
	parameter bit         FOUR_BANKS = 1'b0,
	parameter int         ROW_W      = 15
) (
	// Clock and reset.
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	// Mode-register link.
	umr_if.dev                     mr,
	// Calibration pin strap: high when tied to the supply.
	input  wire logic              cal_pin_tied_high,
	// Refresh query.
	input  wire logic [ROW_W-1:0]  refresh_row,
	input  wire logic [2:0]        refresh_bank,
	output logic                   refresh_blocked,
	// Calibration action pulse and its kind.
	output logic                   cal_start,
	output umr_pkg::umr_cal_e      cal_kind,
	output logic [7:0]             bank_mask,
	output logic [7:0]             seg_mask
);

	// Bank and segment mask width.
	localparam int N_SLOTS = 8;

	// All state of the device end, registered in one place.
	typedef struct packed {
		logic              ack;
		logic [7:0]        rdata;
		logic [7:0]        bank;
		logic [7:0]        seg;
		logic              start;
		umr_pkg::umr_cal_e kind;
		logic              blocked;
		logic              strap_s1;
		logic              strap_s2;
	} umr_dev_s;

	umr_dev_s st_q;
	umr_dev_s st_d;

	// Decoded request and lookups that feed the next-state logic.
	logic               take;
	logic               rd_take;
	logic               wr_take;
	logic               cal_allowed;
	logic               cal_valid;
	umr_pkg::umr_cal_e  cal_decoded;
	logic [7:0]         rd_value;
	logic [7:0]         bank_wr_value;
	logic [2:0]         seg_sel;
	logic [N_SLOTS-1:0] bank_hit;
	logic [N_SLOTS-1:0] seg_hit;

	function automatic logic seg_used(input logic [3:0] dens);
		seg_used = dens >= umr_pkg::DENS_1GB && dens <= umr_pkg::DENS_8GB; // RQ14
	endfunction : seg_used

	function automatic logic [2:0] seg_index(input logic [ROW_W-1:0] row, input logic [3:0] dens);
		if (dens == umr_pkg::DENS_1GB) begin
			seg_index = row[umr_pkg::SEG_LSB_1GB +: 3]; // RQ15
		end else if (dens == umr_pkg::DENS_8GB) begin
			seg_index = row[umr_pkg::SEG_LSB_8GB +: 3]; // RQ15
		end else begin
			seg_index = row[umr_pkg::SEG_LSB_2GB +: 3]; // RQ15
		end
	endfunction : seg_index

	// Geometry word assembled field by field.
	function automatic logic [7:0] geometry_word();
		logic [7:0] w;
		w = umr_pkg::DATA_ZERO;
		w[umr_pkg::TYPE_LSB +: 2] = MEM_TYPE; // RQ3
		w[umr_pkg::DENS_LSB +: 4] = DENSITY; // RQ4
		w[umr_pkg::WIDTH_LSB +: 2] = IO_WIDTH; // RQ3
		return w;
	endfunction : geometry_word

	// Readable addresses give their value; all others read as zero.
	function automatic logic [7:0] read_value(input logic [7:0] a);
		case (a)
			umr_pkg::ADDR_REV_ONE:  read_value = REV_ONE; // RQ1
			umr_pkg::ADDR_REV_TWO:  read_value = REV_TWO; // RQ2
			umr_pkg::ADDR_GEOMETRY: read_value = geometry_word(); // RQ3 RQ4
			default:                read_value = umr_pkg::DATA_ZERO; // RQ16 RQ19
		endcase
	endfunction : read_value

	// Reserved calibration codes decode to no action.
	function automatic umr_pkg::umr_cal_e cal_decode(input logic [7:0] code);
		case (code)
			umr_pkg::CAL_INIT:  cal_decode = umr_pkg::CAL_DO_INI; // RQ6
			umr_pkg::CAL_LONG:  cal_decode = umr_pkg::CAL_DO_LNG; // RQ5
			umr_pkg::CAL_SHORT: cal_decode = umr_pkg::CAL_DO_SHT; // RQ5
			umr_pkg::CAL_RESET: cal_decode = umr_pkg::CAL_DO_RST; // RQ5
			default:            cal_decode = umr_pkg::CAL_NONE; // RQ8
		endcase
	endfunction : cal_decode

	// A request is taken once: the standing ack blocks a second take of the held request.
	assign take = mr.req && !st_q.ack;
	assign rd_take = take && !mr.wr;
	assign wr_take = take && mr.wr;
	assign rd_value = read_value(mr.addr);
	assign cal_decoded = cal_decode(mr.wdata);
	assign cal_valid = cal_decoded != umr_pkg::CAL_NONE; // RQ8
	// The strap comes from a pin and is read only after its second flop.
	assign cal_allowed = !st_q.strap_s2; // RQ9 RQ10
	assign bank_wr_value = FOUR_BANKS ? (mr.wdata & umr_pkg::BANK4_KEEP) : mr.wdata; // RQ12
	assign seg_sel = seg_index(refresh_row, DENSITY); // RQ15

	// One compare per mask bit against the bank or segment under query.
	for (genvar b = 0; b < N_SLOTS; b++) begin : g_slot
		assign bank_hit[b] = st_q.bank[b] && refresh_bank == 3'(b); // RQ11
		assign seg_hit[b] = st_q.seg[b] && seg_sel == 3'(b); // RQ13
	end

	always_comb begin
		st_d = st_q;
		st_d.strap_s1 = cal_pin_tied_high;
		st_d.strap_s2 = st_q.strap_s1;
		// Ack and start are one-cycle pulses.
		st_d.ack = take;
		st_d.start = 1'b0;
		st_d.blocked = (|bank_hit) || (seg_used(DENSITY) && (|seg_hit)); // RQ11 RQ13 RQ14

		// Reads only update the returned data.
		if (rd_take) begin
			st_d.rdata = rd_value; // RQ22
		end

		if (wr_take) begin
			case (mr.addr)
				umr_pkg::ADDR_CAL_CMD: begin
					if (cal_allowed && cal_valid) begin // RQ8 RQ9 RQ10
						st_d.start = 1'b1;
						st_d.kind = cal_decoded; // RQ5 RQ6
					end
				end
				umr_pkg::ADDR_BANK_MASK: st_d.bank = bank_wr_value; // RQ11 RQ12
				umr_pkg::ADDR_SEG_MASK: st_d.seg = mr.wdata; // RQ13
				umr_pkg::ADDR_SOFT_RST: begin
					// Data is ignored; every writable setting returns to its default.
					st_d.bank = umr_pkg::MASK_RESET; // RQ20 RQ21
					st_d.seg = umr_pkg::MASK_RESET; // RQ21
					st_d.kind = umr_pkg::CAL_NONE; // RQ21
				end
				// Read-only, reserved and test addresses ignore writes.
				default: st_d.kind = st_q.kind; // RQ1 RQ2 RQ16 RQ19
			endcase
		end
	end

	// Synchronous reset puts every setting at its default.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q <= '{
				ack:      1'b0,
				rdata:    umr_pkg::DATA_ZERO,
				bank:     umr_pkg::MASK_RESET, // RQ11
				seg:      umr_pkg::MASK_RESET, // RQ13
				start:    1'b0,
				kind:     umr_pkg::CAL_NONE,
				blocked:  1'b0,
				strap_s1: 1'b0,
				strap_s2: 1'b0
			};
		end else begin
			st_q <= st_d;
		end
	end

	// Every output comes straight from a register.
	assign mr.ack = st_q.ack;
	assign mr.rdata = st_q.rdata;
	assign refresh_blocked = st_q.blocked;
	assign cal_start = st_q.start;
	assign cal_kind = st_q.kind;
	assign bank_mask = st_q.bank;
	assign seg_mask = st_q.seg;

endmodule : umr_device

// >>> rtl/umr_ctrl.sv
// Controller end: takes one user request, runs a handshake on the link, returns the answer.
module umr_ctrl (
	// Clock and reset.
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// User side.
	input  wire logic       usr_req,
	input  wire logic       usr_wr,
	input  wire logic [7:0] usr_addr,
	input  wire logic [7:0] usr_wdata,
	output logic            usr_busy,
	output logic            usr_done,
	output logic            usr_refused,
	output logic [7:0]      usr_rdata,
	// Mode-register link.
	umr_if.ctrl             mr
);

	typedef struct packed {
		umr_pkg::umr_hs_e hs;
		logic             req;
		logic             wr;
		logic [7:0]       addr;
		logic [7:0]       wdata;
		logic             done;
		logic             refused;
		logic [7:0]       rdata;
		logic             busy;
	} umr_ctl_s;

	umr_ctl_s st_q;
	umr_ctl_s st_d;

	function automatic logic addr_banned(input logic [7:0] a);
		addr_banned = a >= 8'h14; // RQ17 RQ18
		if (a == umr_pkg::ADDR_SOFT_RST) begin
			addr_banned = 1'b0;
		end
	endfunction : addr_banned

	function automatic logic cal_code_ok(input logic [7:0] d);
		cal_code_ok = d == umr_pkg::CAL_INIT || d == umr_pkg::CAL_LONG ||
			d == umr_pkg::CAL_SHORT || d == umr_pkg::CAL_RESET; // RQ7
	endfunction : cal_code_ok

	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		st_d.refused = 1'b0;
		case (st_q.hs)
			umr_pkg::HS_IDLE: begin
				if (usr_req) begin
					if (addr_banned(usr_addr) || (usr_wr && usr_addr == umr_pkg::ADDR_CAL_CMD
							&& !cal_code_ok(usr_wdata)) ||
							(!usr_wr && usr_addr == umr_pkg::ADDR_SOFT_RST)) begin // RQ20
						st_d.refused = 1'b1;
					end else begin
						st_d.req = 1'b1;
						st_d.wr = usr_wr;
						st_d.addr = usr_addr;
						st_d.wdata = usr_wdata;
						st_d.hs = umr_pkg::HS_WAIT;
					end
				end
			end
			umr_pkg::HS_WAIT: begin
				if (mr.ack) begin
					st_d.req = 1'b0;
					st_d.done = 1'b1;
					st_d.rdata = st_q.wr ? st_q.rdata : mr.rdata;
					st_d.hs = umr_pkg::HS_DONE;
				end
			end
			umr_pkg::HS_DONE: st_d.hs = umr_pkg::HS_IDLE;
			default: st_d.hs = umr_pkg::HS_IDLE;
		endcase
		st_d.busy = st_d.hs != umr_pkg::HS_IDLE;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q <= '{default: '0, hs: umr_pkg::HS_IDLE};
		end else begin
			st_q <= st_d;
		end
	end

	assign mr.req = st_q.req;
	assign mr.wr = st_q.wr;
	assign mr.addr = st_q.addr;
	assign mr.wdata = st_q.wdata;
	assign usr_busy = st_q.busy;
	assign usr_done = st_q.done;
	assign usr_refused = st_q.refused;
	assign usr_rdata = st_q.rdata;

endmodule : umr_ctrl

// >>> verif/umr_link_asserts.sv
module umr_link_asserts #(
	parameter logic [7:0] REV_ONE = 8'h00,
	parameter logic [7:0] REV_TWO = 8'h00,
	parameter logic [7:0] GEOM    = 8'h00
) (
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire logic       req,
	input wire logic       wr,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       ack,
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	logic rd_ack;
	assign rd_ack = ack && !wr;
	property p_ack_next; $rose(req) |=> ack; endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("link ack late");
	property p_ack_pulse; ack |=> !ack; endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("link ack too long");
	property p_req_hold;
		req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request changed before ack");
	property p_req_drop; ack |=> !req [*2]; endproperty
	a_req_drop: assert property (p_req_drop)
		else $error("request not released after ack");
	property p_rev_one; rd_ack && addr == umr_pkg::ADDR_REV_ONE |-> rdata == REV_ONE; endproperty
	a_rev_one: assert property (p_rev_one)
		else $error("bad first revision");
	property p_rev_two; rd_ack && addr == umr_pkg::ADDR_REV_TWO |-> rdata == REV_TWO; endproperty
	a_rev_two: assert property (p_rev_two)
		else $error("bad second revision");
	property p_geom; rd_ack && addr == umr_pkg::ADDR_GEOMETRY |-> rdata == GEOM; endproperty
	a_geom: assert property (p_geom)
		else $error("bad geometry");
	property p_no_read;
		rd_ack && addr >= umr_pkg::ADDR_VEND_TEST && addr <= umr_pkg::ADDR_SEG_MASK |-> rdata == 8'h00;
	endproperty
	a_no_read: assert property (p_no_read)
		else $error("unreadable address returned data");
	property p_range; req |-> addr < 8'h14 || addr == umr_pkg::ADDR_SOFT_RST; endproperty
	a_range: assert property (p_range)
		else $error("forbidden address on link");
	property p_cal_code;
		req && wr && addr == umr_pkg::ADDR_CAL_CMD |-> wdata inside {8'hFF, 8'hAB, 8'h56, 8'hC3};
	endproperty
	a_cal_code: assert property (p_cal_code)
		else $error("undefined calibration code sent");
	property p_rst_wonly; req && addr == umr_pkg::ADDR_SOFT_RST |-> wr; endproperty
	a_rst_wonly: assert property (p_rst_wonly)
		else $error("reset register read");
	c_read: cover property (rd_ack);
	c_cal: cover property (ack && wr && addr == umr_pkg::ADDR_CAL_CMD);
	c_rst: cover property (ack && wr && addr == umr_pkg::ADDR_SOFT_RST);
endmodule : umr_link_asserts

// >>> verif/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] REV1 = 8'h3C; // Arbitrary value.
	localparam logic [7:0] REV2 = 8'hC4; // Arbitrary value.
	localparam logic [7:0] GEOM = {umr_pkg::WIDTH_X16, umr_pkg::DENS_2GB, 2'h0};
	logic              mclk, sys_rst, usr_req, usr_wr, usr_busy, usr_done, usr_refused;
	logic [7:0]        usr_addr, usr_wdata, usr_rdata, bank_mask, seg_mask, r, s;
	logic              strap, blocked, cal_start;
	logic [14:0]       row;
	logic [2:0]        bank;
	umr_pkg::umr_cal_e cal_kind;
	logic [9:0]        e;
	logic [9:0]        q [$];
	logic [31:0]       seed = 32'hEE68;
	logic [7:0]        bad [7] = '{8'h14, 8'h1F, 8'h21, 8'h7F, 8'h80, 8'hBF, 8'hFF};
	logic [7:0]        codes [4] = '{8'hFF, 8'hAB, 8'h56, 8'hC3};
	int                n_errors = 0, total_checks = 0, n_cal = 0, i, n;
	umr_if mr_link ();
	umr_device #(.REV_ONE(REV1), .REV_TWO(REV2)) umr_device_i (.mclk, .sys_rst, .mr(mr_link),
		.cal_pin_tied_high(strap), .refresh_row(row), .refresh_bank(bank),
		.refresh_blocked(blocked), .cal_start, .cal_kind, .bank_mask, .seg_mask);
	umr_ctrl umr_ctrl_i (.mclk, .sys_rst, .usr_req, .usr_wr, .usr_addr, .usr_wdata,
		.usr_busy, .usr_done, .usr_refused, .usr_rdata, .mr(mr_link));
	umr_link_asserts #(.REV_ONE(REV1), .REV_TWO(REV2), .GEOM(GEOM)) umr_link_asserts_i (
		.mclk, .sys_rst, .req(mr_link.req), .wr(mr_link.wr), .addr(mr_link.addr),
		.wdata(mr_link.wdata), .ack(mr_link.ack), .rdata(mr_link.rdata));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	// Expected note: read flag, refused flag, read data.
	task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [9:0] x);
		int k;
		@(posedge mclk);
		#1;
		usr_req = 1'b1;
		usr_wr = w;
		usr_addr = a;
		usr_wdata = d;
		q.push_back(x);
		@(posedge mclk);
		#1;
		usr_req = 1'b0;
		for (k = 0; k < 20 && (usr_busy !== 1'b0 || q.size() != 0); k++) begin
			@(posedge mclk);
			#1;
		end
		if (k == 20) begin
			n_errors++;
			wrap_up();
		end
		@(posedge mclk);
	endtask : op
	always @(negedge mclk) begin
		if (cal_start === 1'b1) n_cal++;
		if ((usr_done === 1'b1 || usr_refused === 1'b1) && q.size() == 0) begin
			chk({8'h0, usr_done, usr_refused}, 10'h000);
		end else if (usr_done === 1'b1 || usr_refused === 1'b1) begin
			e = q.pop_front();
			chk({9'h0, usr_refused}, {9'h0, e[8]});
			if (e[9]) chk({2'h0, usr_rdata}, {2'h0, e[7:0]});
		end
	end
	initial begin
		sys_rst = 1'b1;
		{usr_req, usr_wr, usr_addr, usr_wdata, strap, row, bank} = '0;
		repeat (5) @(posedge mclk);
		#1 sys_rst = 1'b0;
		chk({2'h0, bank_mask}, 10'h000);
		chk({2'h0, seg_mask}, 10'h000);
		op(1'b1, umr_pkg::ADDR_REV_ONE, rnd(), 10'h000);
		op(1'b0, umr_pkg::ADDR_REV_ONE, 8'h00, {2'h2, REV1});
		op(1'b0, umr_pkg::ADDR_REV_TWO, 8'h00, {2'h2, REV2});
		op(1'b0, umr_pkg::ADDR_GEOMETRY, 8'h00, {2'h2, GEOM});
		for (i = 9; i < 18; i++) op(1'b0, i[7:0], 8'h00, 10'h200);
		foreach (bad[j]) op(j[0], bad[j], 8'h00, 10'h100);
		op(1'b0, umr_pkg::ADDR_SOFT_RST, 8'h00, 10'h100);
		op(1'b1, umr_pkg::ADDR_CAL_CMD, 8'h12, 10'h100);
		for (i = 0; i < 4; i++) begin
			n = n_cal;
			op(1'b1, umr_pkg::ADDR_CAL_CMD, codes[i], 10'h000);
			chk({7'h0, cal_kind}, 10'(i + 1));
			chk(10'(n_cal), 10'(n + 1));
		end
		r = rnd();
		op(1'b1, umr_pkg::ADDR_BANK_MASK, r, 10'h000);
		chk({2'h0, bank_mask}, {2'h0, r});
		s = rnd();
		op(1'b1, umr_pkg::ADDR_SEG_MASK, s, 10'h000);
		chk({2'h0, seg_mask}, {2'h0, s});
		for (i = 0; i < 16; i++) begin
			@(posedge mclk);
			#1;
			bank = 3'(rnd());
			row = 15'({rnd(), rnd()});
			@(posedge mclk);
			#1;
			chk({9'h0, blocked}, {9'h0, r[bank] | s[row[umr_pkg::SEG_LSB_2GB +: 3]]});
		end
		op(1'b1, umr_pkg::ADDR_SOFT_RST, rnd(), 10'h000);
		chk({bank_mask, 2'h0}, 10'h000);
		chk({seg_mask, 2'h0}, 10'h000);
		chk({7'h0, cal_kind}, 10'h000);
		#1 strap = 1'b1;
		repeat (3) @(posedge mclk);
		n = n_cal;
		op(1'b1, umr_pkg::ADDR_CAL_CMD, umr_pkg::CAL_LONG, 10'h000);
		chk(10'(n_cal), 10'(n));
		chk({7'h0, cal_kind}, 10'h000);
		wrap_up();
	end
endmodule : testbench
